// [core/edc_pkg.sv]
package edc_pkg;
  // clock rate of clk_sys in kHz
  localparam int unsigned CLK_KHZ = 20000;
  // printed times, in their own units
  localparam int unsigned POWERUP_US = 200;
  localparam int unsigned REFRESH_WINDOW_MS = 16;
  localparam int unsigned REFRESH_ROWS = 1024;
  localparam int unsigned SELF_ROW_US = 125;
  localparam int unsigned INIT_CYCLES = 8;
  // strobe timing minima in ns, self-refresh entry in us (no figures given, plain defaults)
  localparam int unsigned ROW_ACTIVE_NS = 100;
  localparam int unsigned ROW_PRECHARGE_NS = 100;
  localparam int unsigned COL_ACTIVE_NS = 50;
  localparam int unsigned ACCESS_NS = 100;
  localparam int unsigned SELF_ENTRY_US = 100;
  // derived cycle counts, least times rounded up
  localparam int unsigned POWERUP_CYC = POWERUP_US * (CLK_KHZ / 1000);
  localparam int unsigned REFRESH_CYC =
    (REFRESH_WINDOW_MS * CLK_KHZ) / REFRESH_ROWS;
  localparam int unsigned ROW_ACTIVE_CYC = (ROW_ACTIVE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned ROW_PRECHARGE_CYC = (ROW_PRECHARGE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned COL_ACTIVE_CYC = (COL_ACTIVE_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned ACCESS_CYC = (ACCESS_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned SELF_ENTRY_CYC = SELF_ENTRY_US * (CLK_KHZ / 1000);
  localparam int unsigned SELF_ROW_CYC = SELF_ROW_US * (CLK_KHZ / 1000);
  // widths
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CNT_W = 16;
  // host request as it travels through the fifo
  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    logic [9:0] row;
    logic [9:0] col;
    logic [15:0] wdata;
  } edc_req_s;
  localparam int unsigned REQ_W = $bits(edc_req_s);
  // pin bundle driven to the memory
  typedef struct packed {
    logic row_strobe_n;
    logic lower_byte_strobe_n;
    logic upper_byte_strobe_n;
    logic write_strobe_n;
    logic out_enable_n;
    logic [9:0] addr;
  } edc_pins_s;
  localparam edc_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 10'h000};
endpackage

// [core/edc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// small synchronous fifo with valid/ready on both sides
module edc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;
  assign in_ready = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // pointers and fill level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  // storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule
`default_nettype wire

// [core/edc_ctrl.sv]
// Operation
// - start with row low, respect row-active
// - precharge wait before next cycle
// - read at later of column, enable fall
// - write data valid before first fall (here driven in the same cycle as the byte strobes fall)
// - refresh all 1024 rows each 16 ms
// - hold a byte strobe low for it
// - self refresh: hold row low longer
// - leave self refresh, precharge held high
// - distributed refresh resumes without burst
// - other schemes burst all rows after
// - 200 us pause, eight init cycles
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl #(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter int unsigned POWERUP_CYCLES = edc_pkg::POWERUP_CYC,
  parameter int unsigned SELF_ENTRY_CYCLES = edc_pkg::SELF_ENTRY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // request side
  input wire logic req_valid,
  output logic req_ready,
  input wire edc_pkg::edc_req_s req,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // power-save request, level
  input wire logic self_refresh_req,
  output logic self_refresh_active,
  output logic init_done,
  // memory pins
  output logic row_strobe_n,
  output logic lower_byte_strobe_n,
  output logic upper_byte_strobe_n,
  output logic write_strobe_n,
  output logic out_enable_n,
  output logic [9:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe
);
  // one-hot state codes; any other code falls back to idle
  typedef enum logic [8:0] {
    ST_POWERUP = 9'b0_0000_0001,
    ST_IDLE = 9'b0_0000_0010,
    ST_ROW = 9'b0_0000_0100,
    ST_COL = 9'b0_0000_1000,
    ST_END = 9'b0_0001_0000,
    ST_PRE = 9'b0_0010_0000,
    ST_REF_COL = 9'b0_0100_0000,
    ST_REF_ROW = 9'b0_1000_0000,
    ST_SELF = 9'b1_0000_0000
  } edc_state_e;

  // whole controller state in one packed record
  typedef struct packed {
    edc_state_e state;
    logic [15:0] timer;          // generic wait counter
    logic [15:0] ref_timer;      // cycles to next due refresh
    logic [10:0] ref_owed;       // refreshes owed
    logic [3:0] init_cnt;        // init cycles done
    logic init_done;
    logic self_active;
    logic self_exit;             // leaving self refresh
    logic page_open;             // row held for page hit
    logic [9:0] open_row;
    edc_pkg::edc_req_s cur;
    edc_pkg::edc_pins_s pins;
    logic [15:0] dq_out;
    logic [1:0] dq_oe;
    logic rsp_valid;
    logic [15:0] rsp_data;
  } edc_ctl_s;

  // registered state and its next value
  edc_ctl_s r;
  edc_ctl_s next_r;

  // fifo read side
  logic fifo_valid;
  logic fifo_pop;
  edc_pkg::edc_req_s fifo_req;

  // fifo gives back-pressure to the request source
  edc_fifo #(.WIDTH(edc_pkg::REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_req)
  );

  // next-state logic
  always_comb begin
    next_r = r;
    fifo_pop = 1'b0;
    next_r.rsp_valid = 1'b0;
    if (r.timer != '0) begin
      next_r.timer = r.timer - 16'h0001;
    end
    // refresh interval tick; owed grows so no row is skipped
    if (r.ref_timer == '0) begin
      next_r.ref_timer = 16'(edc_pkg::REFRESH_CYC - 1);
      if (!r.self_active) begin
        next_r.ref_owed = r.ref_owed + 11'h001;
      end
    end else begin
      next_r.ref_timer = r.ref_timer - 16'h0001;
    end
    unique case (r.state)
      ST_POWERUP: begin
        // pause, then plain column-first cycles count as init
        if (r.timer == '0) begin
          next_r.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // refresh and init outrank queued requests
        if (!r.init_done || r.ref_owed != '0 || self_refresh_req) begin
          // close an open page before any refresh
          if (r.page_open) begin
            next_r.state = ST_END;
          end else begin
            // column strobes first, no data driven
            next_r.pins = edc_pkg::PINS_IDLE;
            next_r.pins.lower_byte_strobe_n = 1'b0;
            next_r.pins.upper_byte_strobe_n = 1'b0;
            next_r.dq_oe = 2'b00;
            next_r.timer = 16'(edc_pkg::COL_ACTIVE_CYC);
            next_r.state = ST_REF_COL;
          end
        end else if (fifo_valid) begin
          fifo_pop = 1'b1;
          next_r.cur = fifo_req;
          if (r.page_open && fifo_req.row == r.open_row) begin
            // page hit: only a new column is needed
            next_r.state = ST_ROW;
            next_r.timer = '0;
          end else if (r.page_open) begin
            next_r.state = ST_END;
            next_r.page_open = 1'b0;
          end else begin
            next_r.pins.addr = fifo_req.row;
            next_r.pins.row_strobe_n = 1'b0;
            next_r.open_row = fifo_req.row;
            next_r.timer = 16'(edc_pkg::ROW_ACTIVE_CYC);
            next_r.state = ST_ROW;
          end
          // a missed page request waits in cur until the row reopens
          if (r.page_open && fifo_req.row != r.open_row) begin
            next_r.page_open = 1'b0;
          end
        end
      end
      ST_ROW: begin
        if (r.pins.row_strobe_n) begin
          // reopening after a page miss
          next_r.pins.addr = r.cur.row;
          next_r.pins.row_strobe_n = 1'b0;
          next_r.open_row = r.cur.row;
          next_r.timer = 16'(edc_pkg::ROW_ACTIVE_CYC);
        end else if (r.timer == '0) begin
          // row-active runs out before the column; as the row cannot
          // rise before this, the minimum row-low time is kept as well
          // column address, data and strobes set up together
          next_r.pins.addr = r.cur.col;
          next_r.pins.write_strobe_n = !r.cur.write;
          next_r.pins.out_enable_n = r.cur.write;
          next_r.dq_out = r.cur.wdata;
          next_r.dq_oe = r.cur.write ? r.cur.byte_en : 2'b00;
          next_r.pins.lower_byte_strobe_n = !r.cur.byte_en[0];
          next_r.pins.upper_byte_strobe_n = !r.cur.byte_en[1];
          next_r.timer = 16'(edc_pkg::ACCESS_CYC);
          next_r.state = ST_COL;
        end
      end
      ST_COL: begin
        // sample once every access delay has run out
        if (r.timer == '0) begin
          next_r.rsp_valid = !r.cur.write;
          next_r.rsp_data = dq_in;
          // trade: quicker page hits against a row held low longer
          // byte strobes rise, row stays low for page mode
          next_r.pins.lower_byte_strobe_n = 1'b1;
          next_r.pins.upper_byte_strobe_n = 1'b1;
          next_r.pins.write_strobe_n = 1'b1;
          next_r.dq_oe = 2'b00;
          next_r.page_open = 1'b1;
          next_r.state = ST_IDLE;
        end
      end
      ST_END: begin
        // a page miss passes here too, the new request waits in cur
        // row may rise only after row-active has run out
        if (r.timer == '0) begin
          next_r.pins = edc_pkg::PINS_IDLE;
          next_r.dq_oe = 2'b00;
          next_r.page_open = 1'b0;
          next_r.timer = 16'(edc_pkg::ROW_PRECHARGE_CYC);
          next_r.state = ST_PRE;
        end
      end
      ST_PRE: begin
        // a page miss reopens the new row, anything else idles
        if (r.timer == '0) begin
          next_r.state = (r.cur.row != r.open_row) ? ST_ROW : ST_IDLE;
          if (r.cur.row == r.open_row || r.self_exit) begin
            next_r.state = ST_IDLE;
          end
          next_r.self_exit = 1'b0;
        end
      end
      ST_REF_COL: begin
        if (r.timer == '0) begin
          next_r.pins.row_strobe_n = 1'b0;
          next_r.timer = 16'(edc_pkg::ROW_ACTIVE_CYC);
          next_r.state = ST_REF_ROW;
          if (!r.init_done) begin
            next_r.init_cnt = r.init_cnt + 4'h1;
            next_r.init_done = (r.init_cnt == 4'(edc_pkg::INIT_CYCLES - 1));
          end
          // from next_r, so a tick in this same cycle is not lost
          if (next_r.ref_owed != '0) begin
            next_r.ref_owed = next_r.ref_owed - 11'h001;
          end
        end
      end
      ST_REF_ROW: begin
        if (r.timer == '0) begin
          // self refresh only once the init cycles are through
          if (self_refresh_req && r.init_done) begin
            // keep row low past the entry time
            next_r.timer = 16'(SELF_ENTRY_CYCLES);
            next_r.state = ST_SELF;
          end else begin
            next_r.cur.row = r.open_row;
            next_r.state = ST_END;
          end
        end
      end
      ST_SELF: begin
        // an early exit simply closes the refresh row
        if (r.timer == '0) begin
          next_r.self_active = 1'b1;
        end
        if (!self_refresh_req) begin
          // distributed refresh: owed count restarts at zero
          next_r.self_active = 1'b0;
          next_r.self_exit = 1'b1;
          next_r.ref_owed = '0;
          next_r.cur.row = r.open_row;
          next_r.state = ST_END;
          next_r.timer = '0;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
  end

  // state register
  // reset loads constants only, so the pins start idle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.state <= ST_POWERUP;
      r.timer <= 16'(POWERUP_CYCLES);
      r.pins <= edc_pkg::PINS_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // every pin comes straight from the state flops
  assign row_strobe_n = r.pins.row_strobe_n;
  assign lower_byte_strobe_n = r.pins.lower_byte_strobe_n;
  assign upper_byte_strobe_n = r.pins.upper_byte_strobe_n;
  assign write_strobe_n = r.pins.write_strobe_n;
  assign out_enable_n = r.pins.out_enable_n;
  assign addr = r.pins.addr;
  assign dq_out = r.dq_out;
  assign dq_oe = r.dq_oe;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign self_refresh_active = r.self_active;
  assign init_done = r.init_done;
endmodule
`default_nettype wire

// [verif/edc_ctrl_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// pin-level checks on the controller
module edc_ctrl_chk #(
  parameter int unsigned POWERUP_CYCLES = 20,
  parameter int unsigned SELF_ENTRY_CYCLES = 10
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rsp_valid,
  input wire logic self_refresh_active,
  input wire logic init_done,
  input wire logic row_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic write_strobe_n,
  input wire logic out_enable_n,
  input wire logic [1:0] dq_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int unsigned pu_cnt, fall_cnt, low_cnt; // since reset, row falls, row low run
  logic row_q; // row strobe one cycle back
  // helper counters, wide enough for any run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pu_cnt <= 0;
      fall_cnt <= 0;
      low_cnt <= 0;
      row_q <= 1'h1;
    end else begin
      pu_cnt <= pu_cnt + 1;
      row_q <= row_strobe_n;
      if (row_q && !row_strobe_n) fall_cnt <= fall_cnt + 1;
      low_cnt <= row_strobe_n ? 0 : low_cnt + 1;
    end
  end
  // active and precharge minima are two cycles at 20 MHz
  chk_row_active: assert property ($fell(row_strobe_n) |-> !row_strobe_n [*2])
    else $error("row strobe released early");
  chk_row_precharge: assert property ($rose(row_strobe_n) |-> row_strobe_n [*2])
    else $error("row strobe precharge too short");
  chk_init_lanes: assert property (!init_done && $fell(row_strobe_n)
    |-> !(lower_byte_strobe_n && upper_byte_strobe_n))
    else $error("init cycle without byte strobe low");
  chk_write_data: assert property (!row_strobe_n && !write_strobe_n
    |-> (dq_oe | {upper_byte_strobe_n, lower_byte_strobe_n}) == 2'h3)
    else $error("write lane not driven");
  chk_read_quiet: assert property (!out_enable_n |-> dq_oe == 2'h0 && write_strobe_n)
    else $error("read with write strobe or drive");
  chk_powerup_wait: assert property (pu_cnt < POWERUP_CYCLES |-> row_strobe_n)
    else $error("row strobe before power-up wait");
  chk_init_count: assert property ($rose(init_done) |-> ##1 fall_cnt >= edc_pkg::INIT_CYCLES)
    else $error("too few init cycles");
  chk_self_entry: assert property ($rose(self_refresh_active)
    |-> low_cnt >= SELF_ENTRY_CYCLES)
    else $error("self refresh flagged too soon");
  chk_rsp_access: assert property (rsp_valid |-> !$past(out_enable_n))
    else $error("read data taken without output enable");
endmodule
bind edc_ctrl edc_ctrl_chk #(
  .POWERUP_CYCLES(POWERUP_CYCLES), .SELF_ENTRY_CYCLES(SELF_ENTRY_CYCLES)
) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .rsp_valid(rsp_valid),
  .self_refresh_active(self_refresh_active), .init_done(init_done),
  .row_strobe_n(row_strobe_n), .lower_byte_strobe_n(lower_byte_strobe_n),
  .upper_byte_strobe_n(upper_byte_strobe_n), .write_strobe_n(write_strobe_n),
  .out_enable_n(out_enable_n), .dq_oe(dq_oe));
`default_nettype wire

// [verif/edc_dram_model.sv]
`timescale 1ns/1ps
`default_nettype none
// behavioural memory behind the pins
module edc_dram_model (
  input wire logic clk_sys,
  input wire logic row_strobe_n,
  input wire logic lower_byte_strobe_n,
  input wire logic upper_byte_strobe_n,
  input wire logic write_strobe_n,
  input wire logic out_enable_n,
  input wire logic [9:0] addr,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe,
  output logic [15:0] dq_in
);
  logic [15:0] mem [0:255]; // never decays, low nibbles only
  logic [9:0] row; // latched row
  logic ras_q; // row strobe one cycle back
  logic rev_ref = 1'h0; // strobe-reversed refresh cycle
  logic [15:0] hold = 16'h0000; // data kept past column rise
  logic [1:0] hlane = 2'h0; // lanes still driven from hold
  wire [1:0] lane = ~{upper_byte_strobe_n, lower_byte_strobe_n};
  wire cas = |lane; // first fall, last rise
  wire rd_now = !row_strobe_n && cas && write_strobe_n && !rev_ref;
  wire [7:0] idx = {row[3:0], addr[3:0]}; // column within open row
  wire [15:0] cur = mem[idx]; // data at once, simplest timing
  wire [1:0] on = (rd_now ? lane : hlane) & {2{!out_enable_n}};
  wire [15:0] val = rd_now ? cur : hold;
  // released lanes show the inverse, never a stale copy
  assign dq_in = {on[1] ? val[15:8] : ~val[15:8], on[0] ? val[7:0] : ~val[7:0]};
  // strobes sampled on the controller clock
  always @(posedge clk_sys) begin
    ras_q <= row_strobe_n;
    if (ras_q && !row_strobe_n) begin
      rev_ref <= cas; // internal counter row, pins ignored
      if (!cas) row <= addr;
    end
    if (rd_now) begin
      hold <= cur;
      hlane <= lane;
    end else if (row_strobe_n && !cas) hlane <= 2'h0;
    if (!row_strobe_n && cas && !write_strobe_n && !rev_ref) begin
      if (lane[0]) mem[idx][7:0] <= dq_oe[0] ? dq_out[7:0] : ~dq_out[7:0];
      if (lane[1]) mem[idx][15:8] <= dq_oe[1] ? dq_out[15:8] : ~dq_out[15:8];
    end
  end
endmodule
`default_nettype wire

// [verif/test_edo_dram_control_and_refresh.sv]
`timescale 1ns/1ps
`default_nettype none
module test_edo_dram_control_and_refresh;
  logic clk_sys, rst_n, req_valid, self_refresh_req; // driven inputs
  edc_pkg::edc_req_s req; // request word
  logic req_ready, rsp_valid, self_refresh_active, init_done;
  logic row_strobe_n, lower_byte_strobe_n, upper_byte_strobe_n, write_strobe_n, out_enable_n;
  logic [9:0] addr;
  logic [15:0] rsp_data, dq_in, dq_out;
  logic [1:0] dq_oe;
  logic row_q; // row strobe one cycle back
  int err_count, check_count, rev_cnt; // rev_cnt: refresh-only row cycles
  // short power-up and entry times keep the run brief
  edc_ctrl #(.FIFO_DEPTH(8), .POWERUP_CYCLES(20), .SELF_ENTRY_CYCLES(10)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .self_refresh_req(self_refresh_req), .self_refresh_active(self_refresh_active),
    .init_done(init_done), .row_strobe_n(row_strobe_n),
    .lower_byte_strobe_n(lower_byte_strobe_n), .upper_byte_strobe_n(upper_byte_strobe_n),
    .write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  edc_dram_model u_mem (
    .clk_sys(clk_sys), .row_strobe_n(row_strobe_n),
    .lower_byte_strobe_n(lower_byte_strobe_n), .upper_byte_strobe_n(upper_byte_strobe_n),
    .write_strobe_n(write_strobe_n), .out_enable_n(out_enable_n), .addr(addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  // 50 ns period
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  // row falls taken with a byte strobe already low
  always @(posedge clk_sys) begin
    row_q <= row_strobe_n;
    if (row_q && !row_strobe_n && !(lower_byte_strobe_n && upper_byte_strobe_n)) rev_cnt++;
  end
  // one counted comparison
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // counts, verdict, end of run
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait, sampled mid-cycle; sel 0 rsp_valid, 1 init_done, 2 self active
  task automatic wait_for(input int sel, input logic lvl, input string nm);
    int n;
    logic s;
    n = 0;
    s = 1'h0;
    do begin
      @(negedge clk_sys);
      n++;
      s = (sel == 0) ? rsp_valid : (sel == 1) ? init_done : self_refresh_active;
    end while (s !== lvl && n < 2000);
    if (s !== lvl) begin
      chk(nm, {15'h0000, lvl}, {15'h0000, s});
      close_out();
    end
  endtask
  // offers a request, held until taken; valid stays up
  task automatic push(input logic wr, input logic [1:0] be, input logic [9:0] row,
                      input logic [9:0] col, input logic [15:0] wd);
    logic rdy;
    int n;
    rdy = 1'h0;
    n = 0;
    req <= {wr, be, row, col, wd};
    req_valid <= 1'h1;
    while (!rdy && n < 2000) begin
      @(negedge clk_sys);
      rdy = (req_ready === 1'h1);
      @(posedge clk_sys);
      n++;
    end
    if (!rdy) begin
      chk("req_ready", 16'h0001, 16'h0000);
      close_out();
    end
  endtask
  // one read, compared on enabled lanes only
  task automatic rd(input logic [1:0] be, input logic [9:0] row, input logic [9:0] col,
                    input logic [15:0] exp);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    push(1'h0, be, row, col, 16'h0000);
    req_valid <= 1'h0;
    wait_for(0, 1'h1, "rsp_valid");
    chk("rsp_data", exp & m, rsp_data & m);
    @(posedge clk_sys);
  endtask
  // fifo filled while init stalls it, then drained as a page
  task automatic t_fill;
    for (int i = 0; i < 8; i++) push(1'h1, 2'h3, 10'h002, 10'(i), 16'(16'ha000 + i));
    @(negedge clk_sys);
    chk("req_ready full", 16'h0000, {15'h0000, req_ready});
    @(posedge clk_sys);
    req_valid <= 1'h0;
    wait_for(1, 1'h1, "init_done");
    // the last row fall is counted one edge after init_done rises
    @(negedge clk_sys);
    chk("init rows", 16'h0001, {15'h0000, rev_cnt >= 8});
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) rd(2'h3, 10'h002, 10'(i), 16'(16'ha000 + i));
  endtask
  // byte lanes written and read alone
  task automatic t_byte;
    push(1'h1, 2'h3, 10'h009, 10'h001, 16'h1234);
    push(1'h1, 2'h1, 10'h009, 10'h001, 16'habcd);
    push(1'h1, 2'h2, 10'h009, 10'h001, 16'h56ef);
    rd(2'h3, 10'h009, 10'h001, 16'h56cd);
    rd(2'h2, 10'h009, 10'h001, 16'h5600);
    rd(2'h1, 10'h002, 10'h003, 16'ha003);
  endtask
  // idle time must still see periodic row refresh
  task automatic t_refresh;
    int c0;
    c0 = rev_cnt;
    repeat (3 * edc_pkg::REFRESH_CYC) @(posedge clk_sys);
    // look mid-cycle, clear of the counter's own edge
    @(negedge clk_sys);
    chk("refresh rows", 16'h0001, {15'h0000, (rev_cnt - c0) >= 2});
    @(posedge clk_sys);
  endtask
  // self refresh entered, left, data kept
  task automatic t_self;
    self_refresh_req <= 1'h1;
    wait_for(2, 1'h1, "self active");
    chk("row held", 16'h0000, {15'h0000, row_strobe_n});
    @(posedge clk_sys);
    self_refresh_req <= 1'h0;
    wait_for(2, 1'h0, "self exit");
    @(posedge clk_sys);
    rd(2'h3, 10'h009, 10'h001, 16'h56cd);
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    chk("watchdog", 16'h0000, 16'h0001);
    close_out();
  end
  // reset, then scenarios in turn
  initial begin
    rst_n = 1'h0;
    req_valid = 1'h0;
    self_refresh_req = 1'h0;
    req = '0;
    repeat (10) @(posedge clk_sys);
    chk("pins idle", 16'h001f, {11'h000, row_strobe_n, lower_byte_strobe_n,
        upper_byte_strobe_n, write_strobe_n, out_enable_n});
    chk("lanes idle", 16'h0000, {14'h0000, dq_oe});
    rst_n <= 1'h1;
    t_fill();
    t_byte();
    t_refresh();
    t_self();
    close_out();
  end
endmodule
`default_nettype wire
